// file: design/emdp_map.svh
// emdp_map.svh: address map, reset values and timing counts of the expansion bus block
`ifndef EMDP_MAP_SVH
`define EMDP_MAP_SVH
`define EMDP_OFS_DP0_LO 8'h82
`define EMDP_OFS_DP0_HI 8'h83
`define EMDP_OFS_DP1_LO 8'h84
`define EMDP_OFS_DP1_HI 8'h85
`define EMDP_OFS_SEL 8'h86
`define EMDP_SEL_RESET 1'b0
`define EMDP_PTR_RESET 16'h0000
`define EMDP_BYTE_ZERO 8'h00
`define EMDP_SEL_FIRST 1'b0
`define EMDP_SEL_SECOND 1'b1
`define EMDP_PTR_STEP 16'h0001
`define EMDP_CNT_ONE 3'h1
`define EMDP_CNT_ZERO 3'h0
`endif

// file: design/emdp_pkg.sv
// emdp_pkg.sv: types shared by the expansion bus block
package emdp_pkg;
  typedef enum logic [5:0] {
    EMDP_ST_IDLE = 6'b000001,
    EMDP_ST_ALE = 6'b000010,
    EMDP_ST_ADDR = 6'b000100,
    EMDP_ST_STRB = 6'b001000,
    EMDP_ST_END = 6'b010000,
    EMDP_ST_INT = 6'b100000
  } emdp_state_t;
  typedef enum logic [1:0] {
    EMDP_KIND_FETCH = 2'b00,
    EMDP_KIND_READ = 2'b01,
    EMDP_KIND_WRITE = 2'b10
  } emdp_kind_t;
endpackage

// file: design/emdp_iram.sv
// emdp_iram.sv: on-chip data memory with registered read data
`timescale 1ns/1ps
module emdp_iram #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];

  // no reset on the array: contents survive changes of the enable bits
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// file: design/emdp_top.sv
// emdp_top.sv: multiplexed expansion bus with dual data pointers
// Summary of operation
// - fetch strobe acts as program read enable
// - low address/data on port0, high on port2
// - latch strobe falls before port0 turns data
// - data moves address separate 64kB space
// - addresses above on-chip area go external
// - on-chip range served internally when enabled
// - indirect form uses working reg plus port2 latch
// - pointer form outputs full active pointer
// - first pointer at 82h low, 83h high
// - second pointer at 84h low, 85h high
// - select at 86h bit0, others read zero
// - select 0 first pointer, 1 second
// - pointer operations touch selected pointer only
// - incrementing select toggles active pointer
// - reset selects the first pointer
// - on-chip data disabled after reset
`timescale 1ns/1ps
`include "emdp_map.svh"
module emdp_top #(
  parameter int IRAM_DEPTH = 1024,
  parameter int IRAM_AW = 10,
  parameter logic [2:0] STRB_CYC = 3'h2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic active_data_pointer_load,
  input wire logic [15:0] active_data_pointer_load_val,
  input wire logic active_data_pointer_inc,
  output logic [15:0] active_data_pointer,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic ext_data_move,
  input wire logic xmove_write,
  input wire logic xmove_use_ri,
  input wire logic [7:0] indirect_working_reg,
  input wire logic [7:0] p2_latch,
  input wire logic [7:0] xmove_wdata,
  input wire logic data_mem_enable_hi,
  input wire logic data_mem_enable_lo,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic program_fetch_strobe_n,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] p0_out,
  output logic p0_oe,
  input wire logic [7:0] p0_in,
  output logic [7:0] p2_out
);
  logic [15:0] dp0_q, dp0_d, dp1_q, dp1_d;
  logic sel_q, sel_d;
  emdp_pkg::emdp_state_t st_q;
  emdp_pkg::emdp_kind_t kind_q;
  logic [2:0] cnt_q;
  logic [7:0] wdat_q;
  logic [15:0] xaddr;
  logic int_hit, take_x, take_f;
  logic [7:0] iram_q;
  logic iram_we;

  // pointer next values: select, then bytes, then load/increment of the active one
  always_comb begin
    sel_d = sel_q;
    dp0_d = dp0_q;
    dp1_d = dp1_q;
    if (sfr_wr) begin
      case (sfr_addr)
        `EMDP_OFS_DP0_LO: dp0_d[7:0] = sfr_wdata;
        `EMDP_OFS_DP0_HI: dp0_d[15:8] = sfr_wdata;
        `EMDP_OFS_DP1_LO: dp1_d[7:0] = sfr_wdata;
        `EMDP_OFS_DP1_HI: dp1_d[15:8] = sfr_wdata;
        // only bit0 is kept, so an increment of the register flips it
        `EMDP_OFS_SEL: sel_d = sfr_wdata[0];
        default: sel_d = sel_q;
      endcase
    end
    if (active_data_pointer_load || active_data_pointer_inc) begin
      if (sel_q == `EMDP_SEL_FIRST) begin
        dp0_d = active_data_pointer_load ? active_data_pointer_load_val : dp0_q + `EMDP_PTR_STEP;
      end else begin
        dp1_d = active_data_pointer_load ? active_data_pointer_load_val : dp1_q + `EMDP_PTR_STEP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_q <= `EMDP_SEL_RESET;
      dp0_q <= `EMDP_PTR_RESET;
      dp1_q <= `EMDP_PTR_RESET;
      active_data_pointer <= `EMDP_PTR_RESET;
    end else begin
      sel_q <= sel_d;
      dp0_q <= dp0_d;
      dp1_q <= dp1_d;
      // built from next values so the following instruction sees the update
      active_data_pointer <= sel_d ? dp1_d : dp0_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sfr_rdata <= `EMDP_BYTE_ZERO;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `EMDP_OFS_DP0_LO: sfr_rdata <= dp0_q[7:0];
        `EMDP_OFS_DP0_HI: sfr_rdata <= dp0_q[15:8];
        `EMDP_OFS_DP1_LO: sfr_rdata <= dp1_q[7:0];
        `EMDP_OFS_DP1_HI: sfr_rdata <= dp1_q[15:8];
        `EMDP_OFS_SEL: sfr_rdata <= {7'h00, sel_q};
        default: sfr_rdata <= `EMDP_BYTE_ZERO;
      endcase
    end
  end

  // data space address: 16 bits cover the whole 64kB area
  assign xaddr = xmove_use_ri ? {p2_latch, indirect_working_reg}
                              : active_data_pointer;
  // enable inputs are low out of reset when the core clears them, so all goes external
  assign int_hit = data_mem_enable_lo && (32'(xaddr) < IRAM_DEPTH);
  assign take_x = ext_data_move && (st_q == emdp_pkg::EMDP_ST_IDLE);
  assign take_f = fetch_req && !ext_data_move && (st_q == emdp_pkg::EMDP_ST_IDLE);
  assign iram_we = take_x && int_hit && xmove_write;

  emdp_iram #(
    .DEPTH(IRAM_DEPTH),
    .AW(IRAM_AW)
  ) u_iram (
    .clk(clk),
    .we(iram_we),
    .addr(xaddr[IRAM_AW-1:0]),
    .wdata(xmove_wdata),
    .rdata(iram_q)
  );

  // bus sequencer; all pins are registered and move together with the state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= emdp_pkg::EMDP_ST_IDLE;
      kind_q <= emdp_pkg::EMDP_KIND_FETCH;
      cnt_q <= `EMDP_CNT_ZERO;
      wdat_q <= `EMDP_BYTE_ZERO;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= `EMDP_BYTE_ZERO;
      program_fetch_strobe_n <= 1'b1;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      p0_out <= `EMDP_BYTE_ZERO;
      p0_oe <= 1'b0;
      p2_out <= `EMDP_BYTE_ZERO;
    end else begin
      done <= 1'b0;
      case (st_q)
        emdp_pkg::EMDP_ST_IDLE: begin
          if (take_x && int_hit) begin
            st_q <= emdp_pkg::EMDP_ST_INT;
            kind_q <= xmove_write ? emdp_pkg::EMDP_KIND_WRITE : emdp_pkg::EMDP_KIND_READ;
            busy <= 1'b1;
          end else if (take_x || take_f) begin
            st_q <= emdp_pkg::EMDP_ST_ALE;
            if (take_x) begin
              kind_q <= xmove_write ? emdp_pkg::EMDP_KIND_WRITE : emdp_pkg::EMDP_KIND_READ;
            end else begin
              kind_q <= emdp_pkg::EMDP_KIND_FETCH;
            end
            wdat_q <= xmove_wdata;
            busy <= 1'b1;
            ale <= 1'b1;
            p0_out <= take_x ? xaddr[7:0] : fetch_addr[7:0];
            p2_out <= take_x ? xaddr[15:8] : fetch_addr[15:8];
            p0_oe <= 1'b1;
          end
        end
        emdp_pkg::EMDP_ST_ALE: begin
          // address stays on port0 one cycle after the fall, giving the latch hold time
          st_q <= emdp_pkg::EMDP_ST_ADDR;
          ale <= 1'b0;
        end
        emdp_pkg::EMDP_ST_ADDR: begin
          st_q <= emdp_pkg::EMDP_ST_STRB;
          cnt_q <= STRB_CYC;
          case (kind_q)
            emdp_pkg::EMDP_KIND_FETCH: begin
              program_fetch_strobe_n <= 1'b0;
              p0_oe <= 1'b0;
            end
            emdp_pkg::EMDP_KIND_READ: begin
              rd_n <= 1'b0;
              p0_oe <= 1'b0;
            end
            emdp_pkg::EMDP_KIND_WRITE: begin
              wr_n <= 1'b0;
              p0_out <= wdat_q;
            end
            default: p0_oe <= 1'b0;
          endcase
        end
        emdp_pkg::EMDP_ST_STRB: begin
          if (cnt_q == `EMDP_CNT_ONE) begin
            st_q <= emdp_pkg::EMDP_ST_END;
            program_fetch_strobe_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            if (kind_q != emdp_pkg::EMDP_KIND_WRITE) begin
              rdata <= p0_in;
            end
          end
          cnt_q <= cnt_q - `EMDP_CNT_ONE;
        end
        emdp_pkg::EMDP_ST_END: begin
          // write data held one cycle past the strobe rise for memory hold time
          st_q <= emdp_pkg::EMDP_ST_IDLE;
          p0_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
        end
        emdp_pkg::EMDP_ST_INT: begin
          st_q <= emdp_pkg::EMDP_ST_IDLE;
          if (kind_q == emdp_pkg::EMDP_KIND_READ) begin
            rdata <= iram_q;
          end
          busy <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          st_q <= emdp_pkg::EMDP_ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  sequence s_ale_pulse;
    ale ##1 !ale;
  endsequence

  sequence s_addr_then_strobe;
    !ale && p0_oe ##1 (!rd_n || !wr_n || !program_fetch_strobe_n);
  endsequence

  AST_SEL_RESET: assert property (@(posedge clk)
    $rose(rstn) |-> active_data_pointer == dp0_q && !sel_q)
    else $error("select not first pointer after reset");

  AST_SEL_ZERO_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    sfr_rd && sfr_addr == `EMDP_OFS_SEL |=> sfr_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");

  AST_SEL_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)
    sfr_wr && sfr_addr == `EMDP_OFS_SEL && sfr_wdata == {7'h00, sel_q} + 8'h01
      |=> sel_q != $past(sel_q))
    else $error("select increment did not toggle");

  AST_OTHER_PTR_KEPT: assert property (@(posedge clk) disable iff (!rstn)
    (active_data_pointer_load || active_data_pointer_inc) && !sfr_wr && sel_q |=> dp0_q == $past(dp0_q))
    else $error("inactive pointer changed");

  AST_ACTIVE_NEXT: assert property (@(posedge clk) disable iff (!rstn)
    sfr_wr && sfr_addr == `EMDP_OFS_DP0_LO && !sel_q && !active_data_pointer_load && !active_data_pointer_inc
      |=> active_data_pointer[7:0] == $past(sfr_wdata))
    else $error("pointer write not visible next cycle");

  AST_PTR_ADDR: assert property (@(posedge clk) disable iff (!rstn)
    take_x && !int_hit && !xmove_use_ri
      |=> ale && {p2_out, p0_out} == $past(active_data_pointer))
    else $error("pointer address not driven");

  AST_RI_ADDR: assert property (@(posedge clk) disable iff (!rstn)
    take_x && !int_hit && xmove_use_ri
      |=> p0_out == $past(indirect_working_reg) && p2_out == $past(p2_latch))
    else $error("indirect address wrong");

  AST_INT_NO_BUS: assert property (@(posedge clk) disable iff (!rstn)
    take_x && int_hit |=> !ale ##1 !ale && rd_n && wr_n)
    else $error("internal access reached bus");

  AST_LATCH_ORDER: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ale) |-> s_ale_pulse ##0 s_addr_then_strobe)
    else $error("latch strobe order wrong");

  AST_STROBE_AFTER_ALE: assert property (@(posedge clk) disable iff (!rstn)
    $fell(rd_n) || $fell(wr_n) |-> !ale && !$past(ale) && $past(ale, 2))
    else $error("strobe before latch fall");

  AST_FETCH_STROBE: assert property (@(posedge clk) disable iff (!rstn)
    $fell(program_fetch_strobe_n) |-> !p0_oe && rd_n ##2 program_fetch_strobe_n)
    else $error("fetch strobe misuse");

  AST_EXT_WHEN_OFF: assert property (@(posedge clk) disable iff (!rstn)
    take_x && !data_mem_enable_lo |=> ale)
    else $error("disabled memory not routed external");
endmodule

// file: verif/emdp_mem_model.sv
// emdp_mem_model.sv: external address latch with byte-wide memory on the expansion bus
`timescale 1ns/1ps
module emdp_mem_model (
  input wire logic clk,
  input wire logic ale,
  input wire logic [7:0] p0_out,
  input wire logic p0_oe,
  input wire logic [7:0] p2_out,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic program_fetch_strobe_n,
  output logic [7:0] p0_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_q;
  logic [7:0] last_q = 8'h00;
  logic [15:0] addr;
  // transparent while the strobe is high, holds while port0 carries data
  always_latch begin
    if (ale) lat_q <= p0_out;
  end
  assign addr = {p2_out, lat_q};
  always @(posedge clk) begin
    if (!wr_n && p0_oe) mem[addr] <= p0_out;
    last_q <= p0_in;
  end
  // released port shows a changing pattern so a stale byte never passes
  assign p0_in = (!rd_n || !program_fetch_strobe_n) ? mem[addr] : ~last_q;
endmodule

// file: verif/tb.sv
// tb.sv: self-checking bench for the expansion bus block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, active_data_pointer_load = 1'b0;
  logic active_data_pointer_inc = 1'b0, fetch_req = 1'b0, ext_data_move = 1'b0, xmove_write = 1'b0;
  logic xmove_use_ri = 1'b0, data_mem_enable_hi = 1'b0, data_mem_enable_lo = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, indirect_working_reg = 8'h00;
  logic [7:0] p2_latch = 8'h00, xmove_wdata = 8'h00, sfr_rdata, rdata, p0_out, p0_in, p2_out;
  logic [15:0] active_data_pointer_load_val = 16'h0000, fetch_addr = 16'h0000, active_data_pointer;
  logic busy, done, program_fetch_strobe_n, ale, rd_n, wr_n, p0_oe;
  logic [7:0] q;
  int n_errors = 0, checked = 0;
  emdp_top dut_u (
    .clk(clk),
    .rstn(rstn),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata),
    .active_data_pointer_load(active_data_pointer_load),
    .active_data_pointer_load_val(active_data_pointer_load_val),
    .active_data_pointer_inc(active_data_pointer_inc),
    .active_data_pointer(active_data_pointer),
    .fetch_req(fetch_req),
    .fetch_addr(fetch_addr),
    .ext_data_move(ext_data_move),
    .xmove_write(xmove_write),
    .xmove_use_ri(xmove_use_ri),
    .indirect_working_reg(indirect_working_reg),
    .p2_latch(p2_latch),
    .xmove_wdata(xmove_wdata),
    .data_mem_enable_hi(data_mem_enable_hi),
    .data_mem_enable_lo(data_mem_enable_lo),
    .busy(busy),
    .done(done),
    .rdata(rdata),
    .program_fetch_strobe_n(program_fetch_strobe_n),
    .ale(ale),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .p0_out(p0_out),
    .p0_oe(p0_oe),
    .p0_in(p0_in),
    .p2_out(p2_out)
  );
  emdp_mem_model mem_u (
    .clk(clk),
    .ale(ale),
    .p0_out(p0_out),
    .p0_oe(p0_oe),
    .p2_out(p2_out),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .program_fetch_strobe_n(program_fetch_strobe_n),
    .p0_in(p0_in)
  );
  always #10 clk = ~clk;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
    @(posedge clk); #1;
    sfr_wr = 1'b0;
  endtask
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); #1;
    sfr_addr = a; sfr_rd = 1'b1;
    @(posedge clk); #1;
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask
  task automatic pulse_ptr(input logic ld, input logic [15:0] v);
    @(posedge clk); #1;
    active_data_pointer_load = ld; active_data_pointer_inc = !ld; active_data_pointer_load_val = v;
    @(posedge clk); #1;
    active_data_pointer_load = 1'b0; active_data_pointer_inc = 1'b0;
  endtask
  // f: fetch, w: write, ri: working-register form; lat: edges counted from the take edge, itself included, until done is seen
  task automatic xacc(input logic f, w, ri, input logic [15:0] a, input logic [7:0] d,
                      input int lat);
    int n;
    @(posedge clk); #1;
    fetch_req = f; ext_data_move = !f; xmove_write = w; xmove_use_ri = ri;
    fetch_addr = a; p2_latch = a[15:8]; indirect_working_reg = a[7:0]; xmove_wdata = d;
    @(posedge clk); #1;
    fetch_req = 1'b0; ext_data_move = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk); #1;
      n++;
    end
    q = rdata;
    chk(16'(n), 16'(lat));
    chk({15'h0000, busy}, 16'h0000);
  endtask
  task automatic t_reset;
    for (int a = 8'h82; a <= 8'h86; a++) sfr_r(8'(a), 8'h00);
    chk(active_data_pointer, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_regs;
    sfr_w(8'h82, 8'h11); sfr_w(8'h83, 8'h22); sfr_w(8'h84, 8'h33); sfr_w(8'h85, 8'h44);
    sfr_r(8'h82, 8'h11); sfr_r(8'h83, 8'h22);
    sfr_r(8'h84, 8'h33); sfr_r(8'h85, 8'h44);
    chk(active_data_pointer, 16'h2211);
    sfr_w(8'h86, 8'hff);
    chk(active_data_pointer, 16'h4433);
    sfr_r(8'h86, 8'h01);
    sfr_r(8'h87, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_ptr;
    pulse_ptr(1'b0, 16'h0000);
    chk(active_data_pointer, 16'h4434);
    sfr_r(8'h82, 8'h11); sfr_r(8'h83, 8'h22);
    pulse_ptr(1'b1, 16'hffff); pulse_ptr(1'b0, 16'h0000);
    chk(active_data_pointer, 16'h0000);
    sfr_w(8'h86, 8'h02); // select incremented from 01
    sfr_r(8'h86, 8'h00);
    chk(active_data_pointer, 16'h2211);
    $display("test pointer ops done");
  endtask
  task automatic t_ext;
    xacc(1'b0, 1'b1, 1'b0, 16'h0000, 8'ha5, 6);
    chk({8'h00, mem_u.mem[16'h2211]}, 16'h00a5);
    chk({8'h00, p2_out}, 16'h0022);
    xacc(1'b0, 1'b0, 1'b1, 16'h2211, 8'h00, 6);
    chk({8'h00, q}, 16'h00a5);
    mem_u.mem[16'hffff] = 8'h96;
    mem_u.mem[16'h0010] = 8'h5a;
    pulse_ptr(1'b1, 16'hffff);
    xacc(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 6);
    chk({8'h00, q}, 16'h0096);
    xacc(1'b0, 1'b0, 1'b1, 16'h0010, 8'h00, 6);
    chk({8'h00, q}, 16'h005a);
    $display("test external done");
  endtask
  task automatic t_int;
    @(posedge clk); #1;
    data_mem_enable_lo = 1'b1;
    xacc(1'b0, 1'b1, 1'b1, 16'h0010, 8'h3c, 2);
    chk({8'h00, mem_u.mem[16'h0010]}, 16'h005a);
    xacc(1'b0, 1'b0, 1'b1, 16'h0010, 8'h00, 2);
    chk({8'h00, q}, 16'h003c);
    xacc(1'b0, 1'b1, 1'b1, 16'h0400, 8'h77, 6);
    chk({8'h00, mem_u.mem[16'h0400]}, 16'h0077);
    $display("test internal done");
  endtask
  task automatic t_fetch;
    mem_u.mem[16'h1234] = 8'hc3;
    xacc(1'b1, 1'b0, 1'b0, 16'h1234, 8'h00, 6);
    chk({8'h00, q}, 16'h00c3);
    chk({8'h00, p2_out}, 16'h0012);
    $display("test fetch done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset; t_regs; t_ptr; t_ext; t_int; t_fetch;
    tally_and_finish;
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule
